// ---- dv/acm_host_model.sv ----
// Host computer model: sends frame bytes and sinks echo bytes
`timescale 1ns/1ps
module acm_host_model (
   input wire logic ref_clk_i, // System clock
   input wire logic rst_i, // Async reset, high
   input wire logic rx_rdy_i, // Byte taken by the device
   input wire logic tx_vld_i, // Echo byte valid
   input wire logic [7:0] tx_data_i, // Echo byte
   output logic rx_vld_o, // Byte offered
   output logic [7:0] rx_data_o, // Byte value
   output logic tx_rdy_o // Echo byte accepted
);
   logic [7:0] q[$]; // Bytes still to send
   logic [7:0] echo[$]; // Echo bytes collected
   int stall = 0; // Echo accept period, 0 for always ready
   int cnt = 0;
   logic rdy_s;
   logic tx_s;
   logic [7:0] dat_s;
   initial begin
      rx_vld_o = 1'b0;
      rx_data_o = 8'h00;
      tx_rdy_o = 1'b1;
   end
   // Sample handshakes ahead of the edge; they only move on rising edges
   always @(negedge ref_clk_i) begin
      rdy_s = rx_rdy_i;
      tx_s = tx_vld_i && tx_rdy_o;
      dat_s = tx_data_i;
   end
   // Hold each byte until taken; an idle line shows a toggling pattern
   always @(posedge ref_clk_i) begin
      if (tx_s) echo.push_back(dat_s);
      #1;
      if (rx_vld_o && rdy_s) void'(q.pop_front());
      cnt++;
      tx_rdy_o = (stall == 0) || (cnt % stall == 0);
      if (!rst_i && q.size() > 0) begin
         rx_vld_o = 1'b1;
         rx_data_o = q[0];
      end else begin
         rx_vld_o = 1'b0;
         rx_data_o = ~rx_data_o;
      end
   end
endmodule // acm_host_model

// ---- dv/tb_top.sv ----
// Self-checking bench of the audio command interpreter
`timescale 1ns/1ps
module tb_top;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic rx_vld, rx_rdy, tx_vld, tx_rdy, cmd_ok, cmd_err, grp_mode, mute;
   logic [7:0] rx_data, tx_data, src_emb;
   logic [23:0] out_en;
   logic [143:0] vol;
   logic [71:0] grp, route;
   logic [4:0] pre_vld;
   int num_errors = 0;
   int total_checks = 0;

   ////////////////////////////////////////////////////////////////////////
   // Clock, device and host
   always #2 ref_clk_i = ~ref_clk_i;
   acm_audio_cmd uut (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .rx_vld_i(rx_vld),
      .rx_data_i(rx_data),
      .rx_rdy_o(rx_rdy),
      .tx_vld_o(tx_vld),
      .tx_data_o(tx_data),
      .tx_rdy_i(tx_rdy),
      .src_emb_o(src_emb),
      .grp_mode_o(grp_mode),
      .mute_o(mute),
      .out_en_o(out_en),
      .vol_o(vol),
      .grp_o(grp),
      .route_o(route),
      .pre_vld_o(pre_vld),
      .cmd_ok_o(cmd_ok),
      .cmd_err_o(cmd_err)
   );
   acm_host_model host (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .rx_rdy_i(rx_rdy),
      .tx_vld_i(tx_vld),
      .tx_data_i(tx_data),
      .rx_vld_o(rx_vld),
      .rx_data_o(rx_data),
      .tx_rdy_o(tx_rdy)
   );

   ////////////////////////////////////////////////////////////////////////
   // Compare and verdict
   task automatic check(input logic [143:0] seen, input logic [143:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      if (num_errors == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Queue a frame; when terminated, wait for its verdict and its echo
   task automatic send(input string s, input logic term, input logic ok);
      int n;
      for (int i = 0; i < s.len(); i++) host.q.push_back(s[i]);
      if (term) begin
         host.q.push_back(8'h0d);
         host.q.push_back(8'h0a);
         n = 0;
         do begin
            @(posedge ref_clk_i);
            #1;
            n++;
         end while (cmd_ok !== 1'b1 && cmd_err !== 1'b1 && n < 400);
         if (cmd_ok !== 1'b1 && cmd_err !== 1'b1) begin
            num_errors++;
            finish_test();
         end
         check({cmd_ok, cmd_err}, {ok, !ok});
         check({rx_rdy, tx_vld}, {!ok, ok});
         n = 0;
         while (ok && host.echo.size() < s.len() + 2 && n < 400) begin
            @(posedge ref_clk_i);
            #1;
            n++;
         end
         if (ok && host.echo.size() < s.len() + 2) begin
            num_errors++;
            finish_test();
         end
         if (ok) begin
            check(host.echo.size(), s.len() + 2);
            for (int i = 0; i < s.len(); i++) check(host.echo[i], s[i]);
            check({host.echo[s.len()], host.echo[s.len() + 1]}, 16'h0d0a);
         end
         host.echo.delete();
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Command sequence
   initial begin
      repeat (20) @(posedge ref_clk_i);
      #1;
      rst_i = 1'b0;
      check(src_emb, 8'hff);
      check(vol, {24{6'h1e}});
      check(out_en, 24'hffffff);
      check({grp_mode, mute, pre_vld, tx_vld, rx_rdy}, {7'h00, 1'b1});
      check({grp, route}, {{24{3'h1}}, 72'h0});
      send("(in,audio,choose,3,0)", 1, 1);
      check(src_emb, 8'hfb);
      send("(in,audio,choose,3,1)", 1, 1);
      check(src_emb, 8'hff);
      send("(out,audio,grpbing,2,3)", 1, 0);
      send("(out,audio,mode,1)", 1, 1);
      check(grp_mode, 1'b1);
      send("(out,audio,grpbing,2,4)", 1, 1);
      send("(out,audio,grpbing,2,5)", 1, 0);
      check(grp, {{22{3'h1}}, 3'h4, 3'h1});
      send("(out,audio,mode,0)", 1, 1);
      check(grp_mode, 1'b0);
      send("(out,audio,analog,5,1)", 1, 1);
      check(out_en, 24'hffffef);
      send("(out,audio,analog,5,0)", 1, 1);
      check(out_en, 24'hffffff);
      // Echo sink stalls while the volume limits are probed
      host.stall = 3;
      send("(out,audio,volume,7,59)", 1, 1);
      send("(out,audio,volume,7,60)", 1, 0);
      send("(out,audio,volume,7,0)", 1, 0);
      check(vol[41:36], 6'h3b);
      host.stall = 0;
      send("(audio,2,9)", 1, 1);
      check(route, {{15{3'h0}}, 3'h1, {8{3'h0}}});
      send("(audio,4,a)", 1, 1);
      check(route, {24{3'h3}});
      send("(out,audio,mute,1)", 1, 1);
      check({mute, out_en}, {1'b1, 24'h000000});
      send("(out,audio,mute,0)", 1, 1);
      check({mute, out_en}, {1'b0, 24'hffffff});
      send("(audsce,save,1)", 1, 1);
      send("(audsce,save,6)", 1, 0);
      send("(audsce,save,5)", 1, 1);
      check(pre_vld, 5'h11);
      send("(out,audio,volume,7,1)", 1, 1);
      send("(audsce,call,1)", 1, 1);
      check(vol[41:36], 6'h3b);
      send("(audsce,del,1)", 1, 1);
      send("(audsce,call,1)", 1, 0);
      check(pre_vld, 5'h10);
      // An unterminated frame is dropped when the next one starts
      send("(out,audio,mute,1)", 0, 0);
      send("(in,audio,choose,1,0)", 1, 1);
      check({mute, src_emb}, {1'b0, 8'hfe});
      // Six fields and an overlong frame are both refused
      send("(out,audio,volume,7,9,1)", 1, 0);
      send("(out,audio,mute,1                )", 1, 0);
      check({mute, vol[41:36]}, {1'b0, 6'h3b});
      send("(out,audio,loud,1)", 1, 0);
      finish_test();
   end
endmodule // tb_top

// ---- hw/acm_audio_cmd.sv ----
// Audio command interpreter top: field decode, settings, presets, echo
// Operation
// - Input source command: 1 selects embedded audio, 0 external.
// - Output mode command: 1 selects splice-group mode, 0 independent.
// - Output gate command: 0 turns a channel on, 1 turns it off.
// - Volume command accepts levels above 0 and below 60, stores it.
// - Group binding in splice mode accepts groups 1 through 4.
// - Routing command connects one input to one output channel.
// - Routing with output a connects the input to every output.
// - Mute 1 silences all outputs regardless of channel settings.
// - Mute 0 releases the global mute.
// - Presets save, recall or delete, numbers 1 through 5 only.
`timescale 1ns/1ps
module acm_audio_cmd (
   input wire logic ref_clk_i, // System clock
   input wire logic rst_i, // Async reset, high
   input wire logic rx_vld_i, // Received byte valid
   input wire logic [7:0] rx_data_i, // Received byte
   output logic rx_rdy_o, // Byte taken when high
   output logic tx_vld_o, // Echo byte valid
   output logic [7:0] tx_data_o, // Echo byte
   input wire logic tx_rdy_i, // Echo byte taken
   output logic [acm_pkg::NIN-1:0] src_emb_o, // Input uses embedded audio
   output logic grp_mode_o, // Splice-group mode
   output logic mute_o, // Global mute
   output logic [acm_pkg::NOUT-1:0] out_en_o, // Output sound enabled
   output logic [acm_pkg::NOUT*6-1:0] vol_o, // Volume per output
   output logic [acm_pkg::NOUT*3-1:0] grp_o, // Group per output
   output logic [acm_pkg::NOUT*3-1:0] route_o, // Input index per output
   output logic [acm_pkg::NPRE-1:0] pre_vld_o, // Preset slot filled
   output logic cmd_ok_o, // Frame applied
   output logic cmd_err_o // Frame rejected
);
   typedef enum logic {ST_RX, ST_ECHO} acm_st_t;

   acm_tok_if tok ();
   acm_st_t st_q;
   acm_pkg::acm_cfg_t cfg_q, cfg_d;
   acm_pkg::acm_cfg_t pre_q [0:acm_pkg::NPRE-1];
   logic [acm_pkg::NPRE-1:0] pvld_q;
   logic [63:0] ftxt_q [0:acm_pkg::NFLD-1];
   logic [7:0] fnum_q [0:acm_pkg::NFLD-1];
   logic [acm_pkg::NFLD-1:0] fisn_q;
   logic [2:0] nfld_q;
   logic fmany_q;
   logic [7:0] buf_q [0:31];
   logic [5:0] wptr_q;
   logic [5:0] rptr_q;
   logic bovf_q;
   logic pend_q;
   logic [7:0] tx_data_q;
   logic ok_q;
   logic err_q;
   logic [acm_pkg::NOUT-1:0] out_en_q;

   ////////////////////////////////////////////////////////////////////////////
   // Byte intake

   // A byte is taken only outside an echo and not right after a line feed
   assign rx_rdy_o = st_q == ST_RX && !pend_q;
   wire acc = rx_vld_i && rx_rdy_o;
   wire acc_lp = acc && rx_data_i == acm_pkg::CH_LP;
   wire acc_wr = acc && !acc_lp && wptr_q < acm_pkg::BUF_LEN;

   acm_lexer u_lexer (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .byte_vld_i(acc),
      .byte_i(rx_data_i),
      .tok(tok.lexer)
   );

   // Frame text kept for the echo
   always_ff @(posedge ref_clk_i) begin
      if (acc_lp) begin
         buf_q[0] <= rx_data_i;
      end else if (acc_wr) begin
         buf_q[wptr_q[4:0]] <= rx_data_i;
      end
   end

   // Write pointer, overflow and the pause after a line feed
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wptr_q <= 6'h00;
         bovf_q <= 1'b0;
         pend_q <= 1'b0;
      end else begin
         pend_q <= acc && rx_data_i == acm_pkg::CH_LF;
         if (acc_lp) begin
            wptr_q <= 6'h01;
            bovf_q <= 1'b0;
         end else if (acc_wr) begin
            wptr_q <= wptr_q + 6'h01;
         end else if (acc) begin
            bovf_q <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Field store

   always_ff @(posedge ref_clk_i) begin
      if (tok.fld_vld && tok.fld_idx < 3'h5) begin
         ftxt_q[tok.fld_idx] <= tok.fld_txt;
         fnum_q[tok.fld_idx] <= tok.fld_num;
      end
   end

   // Field count and flags; a new frame starts clean
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         fisn_q <= '0;
         nfld_q <= 3'h0;
         fmany_q <= 1'b0;
      end else if (tok.frm_start) begin
         fisn_q <= '0;
         nfld_q <= 3'h0;
         fmany_q <= 1'b0;
      end else if (tok.fld_vld) begin
         if (tok.fld_idx < 3'h5) begin
            fisn_q[tok.fld_idx] <= tok.fld_isnum;
            nfld_q <= tok.fld_idx + 3'h1;
         end else begin
            fmany_q <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command decode

   wire [7:0] n1 = fnum_q[1];
   wire [7:0] n2 = fnum_q[2];
   wire [7:0] n3 = fnum_q[3];
   wire [7:0] n4 = fnum_q[4];
   wire [7:0] n1m = n1 - 8'h01;
   wire [7:0] n2m = n2 - 8'h01;
   wire [7:0] n3m = n3 - 8'h01;
   wire [2:0] in1 = n1m[2:0];
   wire [4:0] out2 = n2m[4:0];
   wire [2:0] pix = n2m[2:0];
   wire [2:0] in3 = n3m[2:0];
   wire [4:0] out3 = n3m[4:0];
   wire in1_ok = fisn_q[1] && n1 != 8'h00 && n1 <= acm_pkg::NIN_MAX;
   wire out2_ok = fisn_q[2] && n2 != 8'h00 && n2 <= acm_pkg::NOUT_MAX;
   wire in3_ok = fisn_q[3] && n3 != 8'h00 && n3 <= acm_pkg::NIN_MAX;
   wire out3_ok = fisn_q[3] && n3 != 8'h00 && n3 <= acm_pkg::NOUT_MAX;
   wire b3 = fisn_q[3] && n3 <= 8'h01;
   wire b4 = fisn_q[4] && n4 <= 8'h01;
   wire out_aud = ftxt_q[0] == acm_pkg::KW_OUT && ftxt_q[1] == acm_pkg::KW_AUDIO;
   wire [63:0] k2 = ftxt_q[2];
   wire n5 = nfld_q == 3'h5;
   wire n4f = nfld_q == 3'h4;

   // Each command: keyword, field count and range checks
   wire c_src = n5 && ftxt_q[0] == acm_pkg::KW_IN && ftxt_q[1] == acm_pkg::KW_AUDIO
                && k2 == acm_pkg::KW_CHOOSE && in3_ok && b4;
   wire c_mode = n4f && out_aud && k2 == acm_pkg::KW_MODE && b3;
   wire c_gate = n5 && out_aud && k2 == acm_pkg::KW_ANALOG && out3_ok && b4;
   wire c_vol = n5 && out_aud && k2 == acm_pkg::KW_VOLUME && out3_ok && fisn_q[4]
                && n4 != 8'h00 && n4 < acm_pkg::VOL_LIM;
   wire c_grp = n5 && out_aud && k2 == acm_pkg::KW_GRPBING && out3_ok && fisn_q[4]
                && n4 != 8'h00 && n4 <= acm_pkg::GRP_LIM && cfg_q.grp_mode;
   wire c_mute = n4f && out_aud && k2 == acm_pkg::KW_MUTE && b3;
   wire aud = nfld_q == 3'h3 && ftxt_q[0] == acm_pkg::KW_AUDIO && in1_ok;
   wire c_rt = aud && out2_ok;
   wire c_rtall = aud && !fisn_q[2] && k2 == acm_pkg::KW_ALL;
   wire pre = nfld_q == 3'h3 && ftxt_q[0] == acm_pkg::KW_AUDSCE && fisn_q[2]
              && n2 != 8'h00 && n2 <= acm_pkg::PRE_LIM;
   wire c_save = pre && ftxt_q[1] == acm_pkg::KW_SAVE;
   wire c_call = pre && ftxt_q[1] == acm_pkg::KW_CALL && pvld_q[pix];
   wire c_del = pre && ftxt_q[1] == acm_pkg::KW_DEL;
   wire cmd_ok = !fmany_q && !bovf_q && (c_src || c_mode || c_gate || c_vol || c_grp
                 || c_mute || c_rt || c_rtall || c_save || c_call || c_del);
   wire apply = tok.frm_done && cmd_ok;

   ////////////////////////////////////////////////////////////////////////////
   // Settings

   // Next settings image for the decoded command
   always_comb begin
      cfg_d = cfg_q;
      if (apply) begin
         if (c_src) cfg_d.src_emb[in3] = n4[0];
         if (c_mode) cfg_d.grp_mode = n3[0];
         if (c_gate) cfg_d.gate_off[out3] = n4[0];
         if (c_vol) cfg_d.vol[out3] = n4[5:0];
         if (c_grp) cfg_d.grp[out3] = n4[2:0];
         if (c_mute) cfg_d.mute = n3[0];
         if (c_rt) cfg_d.route[out2] = in1;
         if (c_rtall) cfg_d.route = {acm_pkg::NOUT{in1}};
         if (c_call) cfg_d = pre_q[pix];
      end
   end

   // Settings, preset flags and result pulses
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cfg_q <= acm_pkg::CFG_RST;
         pvld_q <= '0;
         ok_q <= 1'b0;
         err_q <= 1'b0;
         out_en_q <= ~acm_pkg::CFG_RST.gate_off & {acm_pkg::NOUT{!acm_pkg::CFG_RST.mute}};
      end else begin
         cfg_q <= cfg_d;
         ok_q <= apply;
         out_en_q <= ~cfg_d.gate_off & {acm_pkg::NOUT{!cfg_d.mute}};
         err_q <= tok.frm_done && !cmd_ok;
         if (apply && c_save) pvld_q[pix] <= 1'b1;
         if (apply && c_del) pvld_q[pix] <= 1'b0;
      end
   end

   // Preset storage
   always_ff @(posedge ref_clk_i) begin
      if (apply && c_save) pre_q[pix] <= cfg_q;
   end

   // Per-output views of the settings
   for (genvar g = 0; g < acm_pkg::NOUT; g++) begin : g_out
      assign vol_o[g*6 +: 6] = cfg_q.vol[g];
      assign grp_o[g*3 +: 3] = cfg_q.grp[g];
      assign route_o[g*3 +: 3] = cfg_q.route[g];
   end

   assign out_en_o = out_en_q;
   assign src_emb_o = cfg_q.src_emb;
   assign grp_mode_o = cfg_q.grp_mode;
   assign mute_o = cfg_q.mute;
   assign pre_vld_o = pvld_q;
   assign cmd_ok_o = ok_q;
   assign cmd_err_o = err_q;

   ////////////////////////////////////////////////////////////////////////////
   // Echo of an applied frame

   wire last = rptr_q == wptr_q;

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= ST_RX;
         rptr_q <= 6'h00;
         tx_data_q <= 8'h00;
      end else if (st_q == ST_RX) begin
         if (apply) begin
            st_q <= ST_ECHO;
            tx_data_q <= buf_q[0];
            rptr_q <= 6'h01;
         end
      end else if (tx_rdy_i) begin
         if (last) begin
            st_q <= ST_RX;
         end else begin
            tx_data_q <= buf_q[rptr_q[4:0]];
            rptr_q <= rptr_q + 6'h01;
         end
      end
   end

   assign tx_vld_o = st_q == ST_ECHO;
   assign tx_data_o = tx_data_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   sequence s_applied;
      tok.frm_done && cmd_ok;
   endsequence

   sequence s_echo_open;
      tx_vld_o && tx_data_o == acm_pkg::CH_LP;
   endsequence

   chk_echo_only_frame: assert property ($rose(tx_vld_o) |-> $past(tok.frm_done))
      else $error("echo without a finished frame");
   chk_src_select: assert property (tok.frm_done && cmd_ok && c_src
      |=> src_emb_o[$past(in3)] == $past(n4[0]))
      else $error("input source not stored");
   chk_mode_set: assert property (tok.frm_done && cmd_ok && c_mode
      |=> grp_mode_o == $past(n3[0]))
      else $error("output mode not stored");
   chk_gate_polarity: assert property (tok.frm_done && cmd_ok && c_gate && !mute_o
      |=> out_en_o[$past(out3)] == !$past(n4[0]))
      else $error("gate polarity wrong");
   chk_vol_store: assert property (tok.frm_done && cmd_ok && c_vol
      |=> cfg_q.vol[$past(out3)] == $past(n4[5:0]) && $past(n4) < acm_pkg::VOL_LIM)
      else $error("volume store or range wrong");
   chk_grp_range: assert property (tok.frm_done && cmd_ok && c_grp
      |=> cfg_q.grp[$past(out3)] inside {[3'h1:3'h4]} && grp_mode_o)
      else $error("group binding out of range");
   chk_route_one: assert property (tok.frm_done && cmd_ok && c_rt
      |=> cfg_q.route[$past(out2)] == $past(in1))
      else $error("single route not stored");
   chk_route_all: assert property (tok.frm_done && cmd_ok && c_rtall
      |=> cfg_q.route[0] == $past(in1) && cfg_q.route[23] == $past(in1))
      else $error("route to all not stored");
   chk_mute_silence: assert property (mute_o |-> out_en_o == '0)
      else $error("output live under mute");
   chk_mute_release: assert property (tok.frm_done && cmd_ok && c_mute && n3 == 8'h00
      |=> !mute_o)
      else $error("mute not released");
   chk_preset_num: assert property (tok.frm_done && cmd_ok && pre
      |=> pre_vld_o[$past(pix)] == $past(c_save || (c_call && pvld_q[pix])))
      else $error("preset slot flag wrong");
   chk_echo_start: assert property (s_applied |=> s_echo_open ##0 cmd_ok_o)
      else $error("applied frame not echoed");
   chk_bad_dropped: assert property (tok.frm_done && !cmd_ok
      |=> !tx_vld_o && cmd_err_o && $stable(cfg_q))
      else $error("rejected frame took effect");
endmodule // acm_audio_cmd

// ---- hw/acm_lexer.sv ----
// Frame lexer: splits a parenthesised frame into fields
`timescale 1ns/1ps
module acm_lexer (
   input wire logic ref_clk_i, // System clock
   input wire logic rst_i, // Async reset, high
   input wire logic byte_vld_i, // Byte accepted this cycle
   input wire logic [7:0] byte_i, // Byte value
   acm_tok_if.lexer tok // Token stream
);
   typedef enum logic [1:0] {LX_IDLE, LX_FIELD, LX_CR, LX_LF} acm_lx_t;
   acm_lx_t st_q, st_d;
   logic [63:0] txt_q;
   logic [7:0] num_q;
   logic [3:0] len_q;
   logic nonum_q;
   logic [2:0] idx_q;

   // Character classes and digit accumulation
   wire is_lp = byte_i == acm_pkg::CH_LP;
   wire is_rp = byte_i == acm_pkg::CH_RP;
   wire is_cm = byte_i == acm_pkg::CH_COMMA;
   wire is_cr = byte_i == acm_pkg::CH_CR;
   wire is_lf = byte_i == acm_pkg::CH_LF;
   wire is_sp = byte_i == acm_pkg::CH_SP;
   wire is_dig = byte_i >= acm_pkg::CH_0 && byte_i <= acm_pkg::CH_9;
   wire [11:0] num_nx = {4'h0, num_q} * 12'h00a + {8'h00, byte_i[3:0]};
   wire in_fld = byte_vld_i && st_q == LX_FIELD && !is_lp;
   wire fld_end = in_fld && (is_cm || is_rp);
   wire done = byte_vld_i && st_q == LX_LF && is_lf;
   wire abort = byte_vld_i && st_q != LX_IDLE && st_d == LX_IDLE && !done;

   // Frame sequence; a stray byte drops a partial frame
   always_comb begin
      st_d = st_q;
      if (byte_vld_i) begin
         if (is_lp) begin
            st_d = LX_FIELD;
         end else begin
            unique case (st_q)
               LX_IDLE: st_d = LX_IDLE;
               LX_FIELD: st_d = is_rp ? LX_CR : ((is_cr || is_lf) ? LX_IDLE : LX_FIELD);
               LX_CR: st_d = is_cr ? LX_LF : (is_sp ? LX_CR : LX_IDLE);
               LX_LF: st_d = LX_IDLE;
            endcase
         end
      end
   end

   // Field accumulator
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= LX_IDLE;
         txt_q <= 64'h0;
         num_q <= 8'h00;
         len_q <= 4'h0;
         nonum_q <= 1'b0;
         idx_q <= 3'h0;
      end else begin
         st_q <= st_d;
         if (byte_vld_i && (is_lp || fld_end)) begin
            txt_q <= 64'h0;
            num_q <= 8'h00;
            len_q <= 4'h0;
            nonum_q <= 1'b0;
            idx_q <= is_lp ? 3'h0 : (idx_q == 3'h7 ? idx_q : idx_q + 3'h1);
         end else if (in_fld && !is_sp) begin
            txt_q <= {txt_q[55:0], byte_i};
            num_q <= num_nx[7:0];
            len_q <= (len_q == 4'h9) ? len_q : len_q + 4'h1;
            nonum_q <= nonum_q | !is_dig | (num_nx > 12'h0ff);
         end
      end
   end

   // Registered token outputs
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tok.fld_vld <= 1'b0;
         tok.fld_idx <= 3'h0;
         tok.fld_txt <= 64'h0;
         tok.fld_num <= 8'h00;
         tok.fld_isnum <= 1'b0;
         tok.frm_start <= 1'b0;
         tok.frm_done <= 1'b0;
         tok.frm_abort <= 1'b0;
      end else begin
         tok.fld_vld <= fld_end;
         tok.fld_idx <= idx_q;
         tok.fld_txt <= (len_q > 4'h8) ? 64'h0 : txt_q;
         tok.fld_num <= num_q;
         tok.fld_isnum <= !nonum_q && len_q != 4'h0;
         tok.frm_start <= byte_vld_i && is_lp;
         tok.frm_done <= done;
         tok.frm_abort <= abort;
      end
   end

   chk_lex_done_lf: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      tok.frm_done |-> $past(byte_vld_i && is_lf))
      else $error("frame end without line feed");
endmodule // acm_lexer

// ---- hw/acm_pkg.sv ----
// Shared constants and types of the audio command interpreter
package acm_pkg;
   // Channel, preset and field counts and the 8-bit limits for field checks
   localparam int NIN = 8;
   localparam int NOUT = 24;
   localparam logic [7:0] NIN_MAX = 8'h08;
   localparam logic [7:0] NOUT_MAX = 8'h18;
   localparam logic [7:0] VOL_LIM = 8'h3c;
   localparam logic [7:0] GRP_LIM = 8'h04;
   localparam logic [7:0] PRE_LIM = 8'h05;
   localparam int NPRE = 5;
   localparam int NFLD = 5;

   // Frame buffer depth in bytes
   localparam logic [5:0] BUF_LEN = 6'h20;

   // Frame characters
   localparam logic [7:0] CH_LP = 8'h28;
   localparam logic [7:0] CH_RP = 8'h29;
   localparam logic [7:0] CH_COMMA = 8'h2c;
   localparam logic [7:0] CH_CR = 8'h0d;
   localparam logic [7:0] CH_LF = 8'h0a;
   localparam logic [7:0] CH_SP = 8'h20;
   localparam logic [7:0] CH_0 = 8'h30;
   localparam logic [7:0] CH_9 = 8'h39;

   // Keywords, right aligned ASCII
   localparam logic [63:0] KW_IN = 64'h696e;
   localparam logic [63:0] KW_OUT = 64'h6f7574;
   localparam logic [63:0] KW_AUDIO = 64'h617564696f;
   localparam logic [63:0] KW_CHOOSE = 64'h63686f6f7365;
   localparam logic [63:0] KW_MODE = 64'h6d6f6465;
   localparam logic [63:0] KW_ANALOG = 64'h616e616c6f67;
   localparam logic [63:0] KW_VOLUME = 64'h766f6c756d65;
   localparam logic [63:0] KW_GRPBING = 64'h67727062696e67;
   localparam logic [63:0] KW_MUTE = 64'h6d757465;
   localparam logic [63:0] KW_AUDSCE = 64'h617564736365;
   localparam logic [63:0] KW_SAVE = 64'h73617665;
   localparam logic [63:0] KW_CALL = 64'h63616c6c;
   localparam logic [63:0] KW_DEL = 64'h64656c;
   localparam logic [63:0] KW_ALL = 64'h61;

   // Audio settings image, also the preset word
   typedef struct packed {
      logic [NIN-1:0] src_emb;
      logic grp_mode;
      logic [NOUT-1:0] gate_off;
      logic [NOUT-1:0][5:0] vol;
      logic [NOUT-1:0][2:0] grp;
      logic [NOUT-1:0][2:0] route;
      logic mute;
   } acm_cfg_t;

   // Values after reset
   localparam logic [5:0] VOL_RST = 6'h1e;
   localparam logic [2:0] GRP_RST = 3'h1;
   localparam acm_cfg_t CFG_RST = '{
      src_emb: {NIN{1'b1}},
      grp_mode: 1'b0,
      gate_off: {NOUT{1'b0}},
      vol: {NOUT{VOL_RST}},
      grp: {NOUT{GRP_RST}},
      route: {(NOUT*3){1'b0}},
      mute: 1'b0
   };
endpackage

// ---- hw/acm_tok_if.sv ----
// Token stream from the frame lexer to the command core
`timescale 1ns/1ps
interface acm_tok_if;
   logic fld_vld;
   logic [2:0] fld_idx;
   logic [63:0] fld_txt;
   logic [7:0] fld_num;
   logic fld_isnum;
   logic frm_start;
   logic frm_done;
   logic frm_abort;
   modport lexer (output fld_vld, fld_idx, fld_txt, fld_num, fld_isnum,
                  output frm_start, frm_done, frm_abort);
   modport core (input fld_vld, fld_idx, fld_txt, fld_num, fld_isnum,
                 input frm_start, frm_done, frm_abort);
endinterface
